// file: verilog/bwc_pkg.sv
// Constants for the bridge window configuration registers
//
// How it works
// - Bits 19:16 of the prefetchable limit register are read-only and always read 1h (64-bit).
// - Limit bits 31:20 at 24h are writable, give top address bits 31:20, reset 000h.
// - The 20 low bits of the prefetchable top address are taken as all ones, not stored.
// - The 32-bit writable register at 28h gives bits 63:32 of the prefetchable bottom address.
// - The 32-bit writable register at 2Ch gives bits 63:32 of the prefetchable top address.
// - Bits 15:0 at 30h are writable, give I/O bottom address bits 31:16, reset zero.
// - Bits 31:16 at 30h are writable, give I/O top address bits 31:16, reset zero.
// - Bits 7:0 at 34h are a read-only capability pointer that reads 40h.
// - The 20 low bits of the prefetchable bottom address are taken as zero.
package bwc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_PREF_TOP_LOW = 8'h24;
  localparam logic [7:0] OFF_PREF_BOT_HIGH = 8'h28;
  localparam logic [7:0] OFF_PREF_TOP_HIGH = 8'h2c;
  localparam logic [7:0] OFF_IO_HIGH = 8'h30;
  localparam logic [7:0] OFF_CAP_START = 8'h34;
  localparam logic [7:0] OFF_IRQ_SCRATCH = 8'h3c;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int LIMIT_LSB = 20;
  localparam int LIMIT_MSB = 31;
  localparam int ADDR64_LSB = 16;
  localparam int ADDR64_MSB = 19;
  localparam int IO_BOT_LSB = 0;
  localparam int IO_BOT_MSB = 15;
  localparam int IO_TOP_LSB = 16;
  localparam int IO_TOP_MSB = 31;
  localparam int CAP_MSB = 7;
  localparam int IRQ_MSB = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed field contents
  localparam logic [11:0] RST_PREF_LIMIT = 12'h000;
  localparam logic [31:0] RST_PREF_BOT_HIGH = 32'h0000_0000;
  localparam logic [31:0] RST_PREF_TOP_HIGH = 32'h0000_0000;
  localparam logic [15:0] RST_IO_BOT_HIGH = 16'h0000;
  localparam logic [15:0] RST_IO_TOP_HIGH = 16'h0000;
  localparam logic [7:0] RST_IRQ_SCRATCH = 8'h00;
  localparam logic [3:0] ADDR64_CODE = 4'h1;
  localparam logic [7:0] CAP_START_VAL = 8'h40;
  localparam logic [19:0] TOP_LOW_FILL = 20'hf_ffff;
  localparam logic [19:0] BOT_LOW_FILL = 20'h0_0000;

endpackage

// file: verilog/bwc_win_if.sv
// Window bounds and hit carried between the register bank and the comparator
`timescale 1ns/10ps
interface bwc_win_if;
  logic [63:0] bottom;
  logic [63:0] top;
  logic [63:0] addr;
  logic hit;

  modport cfg (output bottom, output top, output addr, input hit);
  modport cmp (input bottom, input top, input addr, output hit);
endinterface

// file: verilog/bwc_window_cmp.sv
// Inclusive range compare of one address against one window
`timescale 1ns/10ps
module bwc_window_cmp (
  bwc_win_if.cmp win
);

  // Bottom above top gives an empty window, nothing hits
  always_comb begin
    win.hit = (win.addr >= win.bottom) && (win.addr <= win.top);
  end

endmodule

// file: verilog/bwc_regs.sv
// Bridge window configuration registers with APB access and window hit flags
`timescale 1ns/10ps
module bwc_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] pref_base_field,
  input wire logic [15:0] io_bottom_low,
  input wire logic [15:0] io_top_low,
  input wire logic [63:0] mem_addr,
  input wire logic [31:0] io_addr,
  output logic pref_hit,
  output logic io_hit
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [11:0] pref_limit_r;
  logic [31:0] pref_bot_high_r;
  logic [31:0] pref_top_high_r;
  logic [15:0] io_bot_high_r;
  logic [15:0] io_top_high_r;
  logic [7:0] irq_scratch_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic pref_hit_r;
  logic io_hit_r;

  logic pready_nxt;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic addr_hit;
  logic wr_en;
  logic [7:0] word_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of write data into the current word

  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux

  assign word_addr = {paddr[7:2], 2'b00};

  always_comb begin
    rd_word = 32'h0000_0000;
    addr_hit = 1'b1;
    if (word_addr == bwc_pkg::OFF_PREF_TOP_LOW) begin
      rd_word[bwc_pkg::LIMIT_MSB:bwc_pkg::LIMIT_LSB] = pref_limit_r;
      rd_word[bwc_pkg::ADDR64_MSB:bwc_pkg::ADDR64_LSB] = bwc_pkg::ADDR64_CODE;
    end else if (word_addr == bwc_pkg::OFF_PREF_BOT_HIGH) begin
      rd_word = pref_bot_high_r;
    end else if (word_addr == bwc_pkg::OFF_PREF_TOP_HIGH) begin
      rd_word = pref_top_high_r;
    end else if (word_addr == bwc_pkg::OFF_IO_HIGH) begin
      rd_word[bwc_pkg::IO_BOT_MSB:bwc_pkg::IO_BOT_LSB] = io_bot_high_r;
      rd_word[bwc_pkg::IO_TOP_MSB:bwc_pkg::IO_TOP_LSB] = io_top_high_r;
    end else if (word_addr == bwc_pkg::OFF_CAP_START) begin
      rd_word[bwc_pkg::CAP_MSB:0] = bwc_pkg::CAP_START_VAL;
    end else if (word_addr == bwc_pkg::OFF_IRQ_SCRATCH) begin
      rd_word[bwc_pkg::IRQ_MSB:0] = irq_scratch_r;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Unstrobed bytes come back unchanged from rd_word; read-only fields are never stored, so writes cannot touch them
  assign wr_word = lane_merge(rd_word, pwdata, pstrb);

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, answer in the second access cycle

  assign pready_nxt = psel && penable && !pready_r;
  assign wr_en = psel && penable && pready_r && pwrite && addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
    end
  end

  // Read data and error are loaded on the same edge that raises pready and held with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (pready_nxt) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_r <= !addr_hit;
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pref_limit_r <= bwc_pkg::RST_PREF_LIMIT;
    end else if (wr_en && word_addr == bwc_pkg::OFF_PREF_TOP_LOW) begin
      pref_limit_r <= wr_word[bwc_pkg::LIMIT_MSB:bwc_pkg::LIMIT_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pref_bot_high_r <= bwc_pkg::RST_PREF_BOT_HIGH;
    end else if (wr_en && word_addr == bwc_pkg::OFF_PREF_BOT_HIGH) begin
      pref_bot_high_r <= wr_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pref_top_high_r <= bwc_pkg::RST_PREF_TOP_HIGH;
    end else if (wr_en && word_addr == bwc_pkg::OFF_PREF_TOP_HIGH) begin
      pref_top_high_r <= wr_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_bot_high_r <= bwc_pkg::RST_IO_BOT_HIGH;
      io_top_high_r <= bwc_pkg::RST_IO_TOP_HIGH;
    end else if (wr_en && word_addr == bwc_pkg::OFF_IO_HIGH) begin
      io_bot_high_r <= wr_word[bwc_pkg::IO_BOT_MSB:bwc_pkg::IO_BOT_LSB];
      io_top_high_r <= wr_word[bwc_pkg::IO_TOP_MSB:bwc_pkg::IO_TOP_LSB];
    end
  end

  // Scratch byte for software only; only the APB read mux reads it, no window logic uses it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_scratch_r <= bwc_pkg::RST_IRQ_SCRATCH;
    end else if (wr_en && word_addr == bwc_pkg::OFF_IRQ_SCRATCH) begin
      irq_scratch_r <= wr_word[bwc_pkg::IRQ_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window assembly and compare

  bwc_win_if pref_win ();
  bwc_win_if io_win ();

  assign pref_win.bottom = {pref_bot_high_r, pref_base_field, bwc_pkg::BOT_LOW_FILL};
  assign pref_win.top = {pref_top_high_r, pref_limit_r, bwc_pkg::TOP_LOW_FILL};
  assign pref_win.addr = mem_addr;

  // I/O space is 32 bits; upper half of the compare is zero
  assign io_win.bottom = {32'h0000_0000, io_bot_high_r, io_bottom_low};
  assign io_win.top = {32'h0000_0000, io_top_high_r, io_top_low};
  assign io_win.addr = {32'h0000_0000, io_addr};

  bwc_window_cmp u_pref_cmp (
    .win(pref_win.cmp)
  );

  bwc_window_cmp u_io_cmp (
    .win(io_win.cmp)
  );

  // Registered so the hit outputs come from flops; one cycle behind the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pref_hit_r <= 1'b0;
      io_hit_r <= 1'b0;
    end else begin
      pref_hit_r <= pref_win.hit;
      io_hit_r <= io_win.hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pref_hit = pref_hit_r;
  assign io_hit = io_hit_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  sequence s_done;
    psel && penable && pready;
  endsequence

  property p_wait_state;
    @(posedge pclk) disable iff (!presetn)
      s_setup ##1 s_access |-> !pready ##1 pready;
  endproperty

  sequence s_read_at(logic [7:0] off);
    s_done and (!pwrite && word_addr == off);
  endsequence

  sequence s_wr_done;
    s_done and pwrite;
  endsequence

  AST_APB_WAIT: assert property (p_wait_state)
    else $error("pready did not follow the single wait state");

  AST_ADDR64_RO: assert property (
    @(posedge pclk) disable iff (!presetn)
      (s_done and (!pwrite && word_addr == bwc_pkg::OFF_PREF_TOP_LOW))
      |-> prdata[19:16] == 4'h1 && prdata[15:0] == 16'h0000)
    else $error("addressing field of limit register not 1h");

  AST_LIMIT_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
      (s_done and (pwrite && pstrb == 4'hf && word_addr == bwc_pkg::OFF_PREF_TOP_LOW))
      |=> {pref_limit_r, 20'h0_0000} == ($past(pwdata) & 32'hfff0_0000)
       && pref_win.top[19:0] == 20'hf_ffff)
    else $error("limit field write not taken");

  AST_TOP_INCL: assert property (
    @(posedge pclk) disable iff (!presetn)
      (mem_addr == {pref_top_high_r, pref_limit_r, 20'hf_ffff}
       && pref_win.bottom <= pref_win.top) |=> pref_hit)
    else $error("top address of prefetch window not inside");

  AST_BOT_HIGH_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
      (s_done and (pwrite && pstrb == 4'hf && word_addr == bwc_pkg::OFF_PREF_BOT_HIGH))
      |=> pref_bot_high_r == $past(pwdata) ##1 pref_win.bottom[63:32] == $past(pwdata, 2))
    else $error("bottom upper word write not taken");

  AST_TOP_HIGH_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
      (s_done and (pwrite && pstrb == 4'hf && word_addr == bwc_pkg::OFF_PREF_TOP_HIGH))
      |=> pref_win.top[63:32] == $past(pwdata))
    else $error("top upper word write not taken");

  AST_IO_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
      (s_done and (pwrite && pstrb == 4'hf && word_addr == bwc_pkg::OFF_IO_HIGH))
      |=> {io_top_high_r, io_bot_high_r} == $past(pwdata))
    else $error("I/O upper halves write not taken");

  AST_IO_TOP_HIT: assert property (
    @(posedge pclk) disable iff (!presetn)
      (io_addr == {io_top_high_r, io_top_low} && io_win.bottom <= io_win.top)
      |=> io_hit)
    else $error("I/O top address not inside window");

  AST_CAP_RO: assert property (
    @(posedge pclk) disable iff (!presetn)
      s_read_at(bwc_pkg::OFF_CAP_START) |-> prdata == 32'h0000_0040)
    else $error("capability pointer does not read 40h");

  AST_BOT_INCL: assert property (
    @(posedge pclk) disable iff (!presetn)
      (mem_addr == {pref_bot_high_r, pref_base_field, 20'h0_0000}
       && pref_win.bottom <= pref_win.top) |=> pref_hit)
    else $error("bottom address of prefetch window not inside");

  AST_BELOW_MISS: assert property (
    @(posedge pclk) disable iff (!presetn)
      (mem_addr < pref_win.bottom || mem_addr > pref_win.top) |=> !pref_hit)
    else $error("address outside prefetch window reported as hit");

  AST_IRQ_SCRATCH: assert property (
    @(posedge pclk) disable iff (!presetn)
      (s_done and (pwrite && pstrb[0] && word_addr == bwc_pkg::OFF_IRQ_SCRATCH))
      |=> {24'h00_0000, irq_scratch_r} == ($past(pwdata) & 32'h0000_00ff))
    else $error("scratch byte write not taken");

  AST_UNMAPPED_ERR: assert property (
    @(posedge pclk) disable iff (!presetn)
      (s_done and !addr_hit) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access answered without error");

  // Handshake shape: one-cycle answer, never during setup
  AST_READY_PULSE: assert property (
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
    else $error("pready held for more than one cycle");

  AST_SETUP_QUIET: assert property (
    @(posedge pclk) disable iff (!presetn)
      s_setup |-> !pready)
    else $error("pready high in a setup cycle");

  AST_ERR_WITH_READY: assert property (
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
    else $error("pslverr raised without pready");

  AST_WRITE_NO_DATA: assert property (
    @(posedge pclk) disable iff (!presetn)
      s_wr_done |-> prdata == 32'h0000_0000)
    else $error("write answered with nonzero read data");

  // Write to 28h with strobe 2h must take byte 1 of the write data
  AST_STRB_LANE: assert property (
    @(posedge pclk) disable iff (!presetn)
      (s_done and (pwrite && pstrb == 4'h2 && word_addr == bwc_pkg::OFF_PREF_BOT_HIGH))
      |=> (pref_bot_high_r & 32'h0000_ff00) == ($past(pwdata) & 32'h0000_ff00))
    else $error("strobed byte of bottom upper word not taken");

  AST_REG_KEEP: assert property (
    @(posedge pclk) disable iff (!presetn)
      !wr_en |=> $stable(pref_limit_r) && $stable(pref_bot_high_r) && $stable(pref_top_high_r))
    else $error("window register changed without a write");

  AST_IO_BOT_HIT: assert property (
    @(posedge pclk) disable iff (!presetn)
      (io_addr == {io_bot_high_r, io_bottom_low} && io_win.bottom <= io_win.top)
      |=> io_hit)
    else $error("I/O bottom address not inside window");

  AST_IO_MISS: assert property (
    @(posedge pclk) disable iff (!presetn)
      (io_win.addr < io_win.bottom || io_win.addr > io_win.top) |=> !io_hit)
    else $error("address outside I/O window reported as hit");

endmodule

// file: test/bridge_window_config_regs_test.sv
// Self-checking bench for the bridge window configuration registers
`timescale 1ns/10ps
module bridge_window_config_regs_test;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] pref_base_field;
  logic [15:0] io_bottom_low;
  logic [15:0] io_top_low;
  logic [63:0] mem_addr;
  logic [31:0] io_addr;
  logic pref_hit;
  logic io_hit;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rd_val;
  logic rd_err;

  bwc_regs u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pref_base_field(pref_base_field),
    .io_bottom_low(io_bottom_low),
    .io_top_low(io_top_low),
    .mem_addr(mem_addr),
    .io_addr(io_addr),
    .pref_hit(pref_hit),
    .io_hit(io_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Generous ceiling; the full sequence needs well under 400 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer, entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_val = prdata;
    rd_err = pslverr;
    chk({31'h0, pready}, 32'h0000_0001);
    // Idle cycle keeps psel from being driven twice in one time step
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd_val, exp);
    chk({31'h0, rd_err}, {31'h0, exp_err});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
    chk({31'h0, rd_err}, 32'h0000_0000);
    chk(rd_val, 32'h0000_0000);
  endtask

  task automatic hit_chk(input logic [63:0] ma, input logic [31:0] ia, input logic ep,
                         input logic ei);
    mem_addr <= ma;
    io_addr <= ia;
    @(posedge pclk);
    @(posedge pclk);
    chk({30'h0, pref_hit, io_hit}, {30'h0, ep, ei});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(8'h24, 32'h0001_0000, 1'b0);
    rd(8'h28, 32'h0000_0000, 1'b0);
    rd(8'h2c, 32'h0000_0000, 1'b0);
    rd(8'h30, 32'h0000_0000, 1'b0);
    rd(8'h34, 32'h0000_0040, 1'b0);
    rd(8'h3c, 32'h0000_0000, 1'b0);
  endtask

  task automatic t_access();
    wr(8'h24, 32'hffff_ffff, 4'hf);
    rd(8'h24, 32'hfff1_0000, 1'b0);
    wr(8'h28, 32'ha5a5_5a5a, 4'hf);
    wr(8'h28, 32'hffff_ffff, 4'h2);
    rd(8'h28, 32'ha5a5_ff5a, 1'b0);
    wr(8'h2c, 32'h1234_5678, 4'hf);
    rd(8'h2c, 32'h1234_5678, 1'b0);
    wr(8'h30, 32'hbeef_cafe, 4'hf);
    rd(8'h30, 32'hbeef_cafe, 1'b0);
    wr(8'h34, 32'hffff_ffff, 4'hf);
    rd(8'h34, 32'h0000_0040, 1'b0);
    wr(8'h3c, 32'hffff_ffff, 4'hf);
    rd(8'h3c, 32'h0000_00ff, 1'b0);
    // Unmapped word answers with an error and zero data
    rd(8'h38, 32'h0000_0000, 1'b1);
  endtask

  // Windows sit at 1_1000_0000..1_123f_ffff and 0001_0010..0002_0020
  task automatic t_windows();
    wr(8'h28, 32'h0000_0001, 4'hf);
    wr(8'h2c, 32'h0000_0001, 4'hf);
    wr(8'h24, 32'h1230_0000, 4'hf);
    wr(8'h30, 32'h0002_0001, 4'hf);
    hit_chk(64'h0000_0001_1000_0000, 32'h0001_0010, 1'b1, 1'b1);
    hit_chk(64'h0000_0001_0fff_ffff, 32'h0001_000f, 1'b0, 1'b0);
    hit_chk(64'h0000_0001_123f_ffff, 32'h0002_0020, 1'b1, 1'b1);
    hit_chk(64'h0000_0001_1240_0000, 32'h0002_0021, 1'b0, 1'b0);
    hit_chk(64'h0000_0002_1100_0000, 32'h0001_8000, 1'b0, 1'b1);
    wr(8'h3c, 32'h0000_0000, 4'hf);
    hit_chk(64'h0000_0001_1100_0000, 32'h0001_8000, 1'b1, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    pref_base_field = 12'h100;
    io_bottom_low = 16'h0010;
    io_top_low = 16'h0020;
    mem_addr = 64'h0000_0000_0000_0000;
    io_addr = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_access();
    t_windows();
    give_verdict();
  end
endmodule
